// [rtl/snr_map.svh]
// Purpose: named constants of the serial nonvolatile RAM command port
// Assumes: included by package and top by bare name
// Notes:   definitions only
`ifndef SNR_MAP_SVH
`define SNR_MAP_SVH

`define SNR_ADDR_W        11
`define SNR_DEPTH         2048
`define SNR_AHI_MSB       2
`define SNR_BIT_LAST      3'h7

`define SNR_OP_LATCH_SET  8'h06
`define SNR_OP_LATCH_CLR  8'h04
`define SNR_OP_SR_READ    8'h05
`define SNR_OP_SR_WRITE   8'h01
`define SNR_OP_MEM_READ   8'h03
`define SNR_OP_MEM_WRITE  8'h02

`define SNR_SR_PROTECT_PIN_ENABLE       7
`define SNR_SR_BP_HI      3
`define SNR_SR_BP_LO      2
`define SNR_SR_WEF        1

`define SNR_QTR_BASE      11'h600
`define SNR_HALF_BASE     11'h400

`endif

// [rtl/snr_pkg.sv]
// Purpose: types and shared functions of the command port
// Assumes: snr_map.svh supplies the address width, status bit positions and protect bases; phase codes are local
// Notes:   no timescale in packages
`include "snr_map.svh"

package snr_pkg;

    typedef enum logic [7:0] {
        ph_cmd     = 8'h01,
        ph_addr_hi = 8'h02,
        ph_addr_lo = 8'h04,
        ph_wdata   = 8'h08,
        ph_rdata   = 8'h10,
        ph_sr_rd   = 8'h20,
        ph_sr_wr   = 8'h40,
        ph_ignore  = 8'h80
    } snr_phase_type;

    typedef struct packed {
        logic                    seen_t;
        logic [2:0]              bit_cnt;
        snr_phase_type           phase;
        logic [7:0]              rx;
        logic [`SNR_ADDR_W-1:0]  addr;
        logic                    is_wr;
        logic [7:0]              tx;
        logic                    protect_pin_enable;
        logic [1:0]              bp;
        logic                    set_t;
        logic                    wr_done;
    } snr_link_type;

    typedef struct packed {
        logic [1:0] frm_sync;
        logic       frm_seen;
        logic [1:0] mode_sync;
        logic [7:0] status;
    } snr_sys_type;

    function automatic logic [7:0] snr_status_byte(input logic       protect_pin_enable,
                                                   input logic [1:0] bp,
                                                   input logic       wef);
        logic [7:0] s;
        s = 8'h00;
        s[`SNR_SR_PROTECT_PIN_ENABLE]  = protect_pin_enable;
        s[`SNR_SR_BP_HI] = bp[1];
        s[`SNR_SR_BP_LO] = bp[0];
        s[`SNR_SR_WEF]   = wef;
        return s;
    endfunction

    function automatic logic snr_blocked(input logic [`SNR_ADDR_W-1:0] addr,
                                         input logic [1:0]             bp);
        logic b;
        b = 1'b0;
        unique case (bp)
            2'h0: b = 1'b0;
            2'h1: b = (addr >= `SNR_QTR_BASE);
            2'h2: b = (addr >= `SNR_HALF_BASE);
            2'h3: b = 1'b1;
        endcase
        return b;
    endfunction

endpackage

// [rtl/snr_top.sv]
// Purpose: serial slave front end of a 2048 x 8 nonvolatile RAM
// Assumes: host drives spi_sck_i as a link clock in mode 0 or 3
// Notes:   link logic on spi_sck_i, status view on sys_clk_i
//
// Notes on behaviour
// [RL1] 2048 byte locations; two-byte address, only low 11 bits used.
// [RL2] writes complete within the transfer; no busy time, no polling.
// [RL3] modes 0 and 3 only; mode sampled at each chip-select fall.
// [RL4] input sampled on rising clock; first bit at first rise after select.
// [RL5] host in mode 3 lowers the clock before the first rise.
// [RL6] first byte after select is the command; address and data follow.
// [RL7] latch set and latch clear commands carry no further bytes.
// [RL8] one command per select; host deselects before a new command.
// [RL9] all transfers are bytes, most significant bit first.
// [RL10] output data changes on falling clock edges.
// [RL11] code 06h sets the write-enable latch, 04h clears it.
// [RL12] code 05h returns one byte of current status.
// [RL13] code 01h plus one data byte writes the status register.
// [RL14] codes 03h read and 02h write memory: address then data bytes.
// [RL15] after power-up the write-enable latch is clear.
// [RL16] latch set command sets latch; status bit 1 mirrors it.
// [RL17] status write data never changes the latch flag bit.
// [RL18] any completed write clears the latch at deselect.
// [RL19] latch clear command blocks writes; flag then reads 0.
// [RL20] protect pin low blocks only status writes, when enabled.
// [RL21] host sets the latch in an earlier frame before a status write.
// [RL22] deselected: inputs ignored, output released.
// [RL23] hold low suspends operation and output; host toggles hold with clock low.
// [RL24] status: bit 7 pin enable, bits 3:2 block protect, bit 1 latch.
// [RL25] unknown command codes are ignored until deselect.
`timescale 1ns/1ps
`include "snr_map.svh"

module snr_top #(
    parameter int DEPTH = `SNR_DEPTH
) (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       clk_en_i,
    input  wire logic       spi_sck_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_si_i,
    input  wire logic       spi_hold_n_i,
    input  wire logic       spi_wp_n_i,
    output logic            spi_so_o,
    output logic            spi_so_oe_o,
    output logic [7:0]      status_o,
    output logic            write_enable_flag_o,
    output logic            protect_pin_enable_o,
    output logic            block_protect_hi_o,
    output logic            block_protect_lo_o,
    output logic            spi_mode3_o
);

    localparam snr_pkg::snr_link_type LINK_RST = '{
        seen_t: 1'b0, bit_cnt: 3'h0, phase: snr_pkg::ph_cmd, rx: 8'h00,
        addr: '0, is_wr: 1'b0, tx: 8'h00, protect_pin_enable: 1'b0, bp: 2'h0,
        set_t: 1'b0, wr_done: 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    snr_pkg::snr_link_type       link;
    snr_pkg::snr_link_type       next_link;
    snr_pkg::snr_sys_type        sys;
    snr_pkg::snr_sys_type        next_sys;
    logic [7:0]                  mem [DEPTH];
    logic                        mem_we;
    logic                        frm_t;
    logic                        clr_t;
    logic                        mode3;
    logic                        so;
    logic                        so_oe;
    logic                        wef;
    logic                        new_frame;
    logic                        byte_done;
    logic                        wr_prot;
    logic [2:0]                  cur_cnt;
    logic [7:0]                  rx_byte;
    snr_pkg::snr_phase_type      cur_phase;

    // latch is the difference of a set toggle and a clear toggle
    assign wef     = link.set_t ^ clr_t;
    assign wr_prot = link.protect_pin_enable && !spi_wp_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // frame edges, clocked by the select pin itself

    // the link clock stands still outside frames, so the frame end is
    // taken on the rising select edge and not on a clock edge
    always_ff @(posedge spi_cs_n_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frm_t <= 1'b0;
            clr_t <= 1'b0;                                        // [RL15]
        end else if (spi_hold_n_i) begin                          // [RL23]
            frm_t <= ~frm_t;                                      // [RL8]
            if (link.wr_done && wef) begin
                clr_t <= ~clr_t;                                  // [RL18]
            end
        end
    end

    // clock level at select fall tells mode 3 from mode 0
    always_ff @(negedge spi_cs_n_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode3 <= 1'b0;
        end else if (spi_hold_n_i) begin
            mode3 <= spi_sck_i;                                   // [RL3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side: command decode on rising clock edges

    always_comb begin
        next_link = link;
        mem_we    = 1'b0;
        new_frame = (link.seen_t != frm_t);
        cur_phase = new_frame ? snr_pkg::ph_cmd : link.phase;     // [RL6]
        cur_cnt   = new_frame ? 3'h0 : link.bit_cnt;              // [RL4]
        rx_byte   = {link.rx[6:0], spi_si_i};                     // [RL9]
        // a clock edge while deselected moves nothing
        byte_done = spi_hold_n_i && !spi_cs_n_i && (cur_cnt == `SNR_BIT_LAST);
        if (spi_hold_n_i && !spi_cs_n_i) begin                    // [RL22] [RL23]
            if (new_frame) begin
                next_link.seen_t  = frm_t;
                next_link.wr_done = 1'b0;
            end
            next_link.phase   = cur_phase;
            next_link.rx      = rx_byte;
            next_link.bit_cnt = 3'(cur_cnt + 3'h1);
            if (byte_done) begin
                unique case (cur_phase)
                    snr_pkg::ph_cmd: begin
                        next_link.phase = snr_pkg::ph_ignore;
                        case (rx_byte)
                            `SNR_OP_LATCH_SET: begin              // [RL7]
                                if (!wef) begin
                                    next_link.set_t = ~link.set_t; // [RL11] [RL16]
                                end
                            end
                            `SNR_OP_LATCH_CLR: begin
                                if (wef) begin
                                    next_link.set_t = ~link.set_t; // [RL19]
                                end
                            end
                            `SNR_OP_SR_READ: begin
                                next_link.phase = snr_pkg::ph_sr_rd;
                                next_link.tx = snr_pkg::snr_status_byte(
                                    link.protect_pin_enable, link.bp, wef);     // [RL12]
                            end
                            `SNR_OP_SR_WRITE: begin
                                next_link.phase = snr_pkg::ph_sr_wr; // [RL13]
                            end
                            `SNR_OP_MEM_READ, `SNR_OP_MEM_WRITE: begin
                                next_link.phase = snr_pkg::ph_addr_hi; // [RL14]
                                next_link.is_wr = (rx_byte == `SNR_OP_MEM_WRITE);
                            end
                            default: begin
                                next_link.phase = snr_pkg::ph_ignore; // [RL25]
                            end
                        endcase
                    end
                    snr_pkg::ph_addr_hi: begin
                        // upper five address bits are dropped
                        next_link.addr[`SNR_ADDR_W-1:8] =
                            rx_byte[`SNR_AHI_MSB:0];              // [RL1]
                        next_link.phase = snr_pkg::ph_addr_lo;
                    end
                    snr_pkg::ph_addr_lo: begin
                        next_link.addr[7:0] = rx_byte;
                        if (link.is_wr) begin
                            next_link.phase = snr_pkg::ph_wdata;
                        end else begin
                            next_link.phase = snr_pkg::ph_rdata;
                            next_link.tx = mem[next_link.addr];
                        end
                    end
                    snr_pkg::ph_wdata: begin
                        // byte lands in the array on its eighth edge
                        mem_we = wef && !snr_pkg::snr_blocked(link.addr, link.bp); // [RL2]
                        if (wef) begin
                            next_link.wr_done = 1'b1;             // [RL18]
                        end
                        next_link.addr = `SNR_ADDR_W'(link.addr + 1'b1);
                    end
                    snr_pkg::ph_rdata: begin
                        next_link.addr = `SNR_ADDR_W'(link.addr + 1'b1);
                        next_link.tx = mem[next_link.addr];
                    end
                    snr_pkg::ph_sr_rd: begin
                        next_link.phase = snr_pkg::ph_ignore;
                    end
                    snr_pkg::ph_sr_wr: begin
                        if (wef && !wr_prot) begin                // [RL20]
                            next_link.protect_pin_enable = rx_byte[`SNR_SR_PROTECT_PIN_ENABLE];
                            next_link.bp   = {rx_byte[`SNR_SR_BP_HI],
                                              rx_byte[`SNR_SR_BP_LO]}; // [RL17]
                            next_link.wr_done = 1'b1;             // [RL18]
                        end
                        next_link.phase = snr_pkg::ph_ignore;
                    end
                    snr_pkg::ph_ignore: begin
                        next_link.phase = snr_pkg::ph_ignore;     // [RL8]
                    end
                endcase
            end
        end
    end

    always_ff @(posedge spi_sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link <= LINK_RST;                                     // [RL15]
        end else begin
            link <= next_link;
        end
    end

    always_ff @(posedge spi_sck_i) begin
        if (mem_we) begin
            mem[link.addr] <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side: serial output on falling clock edges

    always_ff @(negedge spi_sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else if (spi_hold_n_i) begin
            so    <= link.tx[~link.bit_cnt];                      // [RL9] [RL10]
            // a stale phase from the last frame never drives past the new frame's first falling edge
            so_oe <= !new_frame && ((link.phase == snr_pkg::ph_rdata) ||
                                    (link.phase == snr_pkg::ph_sr_rd));
        end
    end

    // release is immediate on deselect or hold
    assign spi_so_o    = so;
    assign spi_so_oe_o = so_oe && !spi_cs_n_i && spi_hold_n_i;    // [RL22] [RL23]

    ////////////////////////////////////////////////////////////////////////////
    // system side: status view, captured once per frame end

    always_comb begin
        next_sys = sys;
        next_sys.frm_sync  = {sys.frm_sync[0], frm_t};
        next_sys.mode_sync = {sys.mode_sync[0], mode3};
        if (sys.frm_sync[1] != sys.frm_seen) begin
            // link state is quiet once the frame end has crossed
            next_sys.frm_seen = sys.frm_sync[1];
            next_sys.status   = snr_pkg::snr_status_byte(link.protect_pin_enable, link.bp, wef); // [RL24]
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sys <= '0;
        end else if (clk_en_i) begin
            sys <= next_sys;
        end
    end

    assign status_o             = sys.status;
    assign write_enable_flag_o  = sys.status[`SNR_SR_WEF];
    assign protect_pin_enable_o = sys.status[`SNR_SR_PROTECT_PIN_ENABLE];
    assign block_protect_hi_o   = sys.status[`SNR_SR_BP_HI];
    assign block_protect_lo_o   = sys.status[`SNR_SR_BP_LO];
    assign spi_mode3_o          = sys.mode_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_latch_sets: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL11]
        byte_done && cur_phase == snr_pkg::ph_cmd && rx_byte == `SNR_OP_LATCH_SET
        |=> wef && link.phase == snr_pkg::ph_ignore)
        else $error("latch set command did not set latch");

    a_latch_clears: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL19]
        byte_done && cur_phase == snr_pkg::ph_cmd && rx_byte == `SNR_OP_LATCH_CLR
        |=> !wef)
        else $error("latch clear command left latch set");

    a_status_load: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL12]
        byte_done && cur_phase == snr_pkg::ph_cmd && rx_byte == `SNR_OP_SR_READ
        |=> link.phase == snr_pkg::ph_sr_rd
            && link.tx[`SNR_SR_WEF] == $past(wef)
            && link.tx[`SNR_SR_PROTECT_PIN_ENABLE] == $past(link.protect_pin_enable))
        else $error("status read did not load status byte");

    a_wp_guards: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL20]
        byte_done && cur_phase == snr_pkg::ph_sr_wr && (wr_prot || !wef)
        |=> $stable(link.protect_pin_enable) && $stable(link.bp) && !link.wr_done)
        else $error("protected status write changed status");

    a_wef_untouched: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL17]
        byte_done && cur_phase == snr_pkg::ph_sr_wr |=> $stable(link.set_t))
        else $error("status write data changed latch flag");

    a_addr_low_bits: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL1]
        byte_done && cur_phase == snr_pkg::ph_addr_hi
        |=> link.addr[`SNR_ADDR_W-1:8] == $past(rx_byte[`SNR_AHI_MSB:0])
            && link.phase == snr_pkg::ph_addr_lo)
        else $error("address high byte not taken from low bits");

    a_unknown_ignored: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL25]
        byte_done && cur_phase == snr_pkg::ph_cmd && rx_byte[7:3] != 5'h00
        |=> link.phase == snr_pkg::ph_ignore && $stable(wef))
        else $error("unknown command was acted on");

    a_one_command: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL8]
        link.phase == snr_pkg::ph_ignore && !new_frame && spi_hold_n_i
        |=> link.phase == snr_pkg::ph_ignore || new_frame)
        else $error("second command taken within one frame");

    a_write_marks: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL18]
        byte_done && cur_phase == snr_pkg::ph_wdata && wef
        |-> mem_we == !snr_pkg::snr_blocked(link.addr, link.bp) ##1 link.wr_done)
        else $error("memory write not recorded for latch clear");

    a_hold_freeze: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL23]
        !spi_hold_n_i |=> $stable(link) && !$past(mem_we))
        else $error("state moved while hold was low");

    a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RL24]
        status_o[6:4] == 3'h0 && status_o[0] == 1'b0)
        else $error("reserved status bits not zero");

    a_view_frozen: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RL24]
        !clk_en_i |=> $stable(status_o) && $stable(spi_mode3_o))
        else $error("status view moved while clock enable was low");

    a_desel_frozen: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL22]
        spi_cs_n_i |=> $stable(link))
        else $error("link state moved while deselected");

    a_stale_quiet: assert property (@(negedge spi_sck_i) disable iff (!nrst_i) // [RL22]
        spi_hold_n_i && new_frame |=> !so_oe)
        else $error("output enabled from a stale phase");

    a_cmd_first: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL6]
        new_frame && spi_hold_n_i && !spi_cs_n_i
        |=> link.phase == snr_pkg::ph_cmd && link.bit_cnt == 3'h1)
        else $error("frame did not start with a command bit");

    a_status_once: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL12]
        byte_done && cur_phase == snr_pkg::ph_sr_rd
        |=> link.phase == snr_pkg::ph_ignore)
        else $error("status read gave more than one byte");

    a_write_latched: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL15]
        mem_we |-> wef)
        else $error("memory written with latch clear");

    a_addr_steps: assert property (@(posedge spi_sck_i) disable iff (!nrst_i) // [RL1]
        byte_done && (cur_phase == snr_pkg::ph_wdata || cur_phase == snr_pkg::ph_rdata)
        |=> link.addr == `SNR_ADDR_W'($past(link.addr) + 1'b1))
        else $error("address did not step by one");

    c_status_read: cover property (@(posedge spi_sck_i) disable iff (!nrst_i)
        byte_done && cur_phase == snr_pkg::ph_cmd && rx_byte == `SNR_OP_SR_READ);

    c_status_write: cover property (@(posedge spi_sck_i) disable iff (!nrst_i)
        byte_done && cur_phase == snr_pkg::ph_sr_wr && wef && !wr_prot);

    c_mem_write: cover property (@(posedge spi_sck_i) disable iff (!nrst_i) mem_we);

    c_mode3_frame: cover property (@(negedge spi_cs_n_i) disable iff (!nrst_i) spi_sck_i);

    c_mem_read: cover property (@(posedge spi_sck_i) disable iff (!nrst_i)
        byte_done && cur_phase == snr_pkg::ph_rdata);

endmodule

// [dv/snr_host.sv]
// Purpose: serial host model driving the command port link side
// Assumes: link clock of 30 ns, runs only inside frames
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/1ps
module snr_host (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    output logic      hold_n_o,
    output logic      wp_n_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    logic m3;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
        wp_n_o = 1'b1;
        m3 = 1'b0;
    end
    task automatic protect(input logic v);
        wp_n_o = v;
    endtask
    task automatic start(input logic mode3);
        m3 = mode3;
        sck_o = mode3;
        #20 cs_n_o = 1'b0;
        #10 sck_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            si_o = b[i];
            #15 sck_o = 1'b1;
            r[i] = (so_oe_i === 1'b1) ? so_i : 1'bx;
            #15 sck_o = 1'b0;
        end
    endtask
    // hold changes with the clock low only
    task automatic pause(output logic oe);
        #5 hold_n_o = 1'b0;
        repeat (3) begin
            #15 sck_o = 1'b1;
            #15 sck_o = 1'b0;
        end
        oe = so_oe_i;
        #15 hold_n_o = 1'b1;
    endtask
    task automatic stop();
        #15 cs_n_o = 1'b1;
        // clock returns to idle only after the frame has ended
        #5 sck_o = m3;
        si_o = ~si_o;
    endtask
endmodule

// [dv/tb_spi_nonvolatile_ram_command_port.sv]
// Purpose: self-checking bench of the command port
// Assumes: host model drives the serial side
// Notes:   status view checked after some frames only, each time once the frame has settled
`timescale 1ns/1ps
module tb_spi_nonvolatile_ram_command_port;
    logic       sys_clk_i = 1'b0;
    logic       nrst_i    = 1'b0;
    logic       clk_en    = 1'b1;
    logic       sck, cs_n, si, hold_n, wp_n, so, so_oe, mode3;
    logic       wef, protect_pin_enable, bph, bpl, oe_seen;
    logic [7:0] status, r0, r1;
    logic [7:0] tx [5];
    logic [7:0] rx [5];
    int         fails     = 0;
    int         cmp_count = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    snr_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
                   .wp_n_o(wp_n), .so_i(so), .so_oe_i(so_oe));
    snr_top dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
                 .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_si_i(si),
                 .spi_hold_n_i(hold_n), .spi_wp_n_i(wp_n), .spi_so_o(so),
                 .spi_so_oe_o(so_oe), .status_o(status), .write_enable_flag_o(wef),
                 .protect_pin_enable_o(protect_pin_enable), .block_protect_hi_o(bph),
                 .block_protect_lo_o(bpl), .spi_mode3_o(mode3));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_st(input logic [7:0] exp);
        repeat (6) @(posedge sys_clk_i);
        #1;
        cmp8(status, exp);
        cmp8({protect_pin_enable, 3'h0, bph, bpl, wef, 1'b0}, exp);
    endtask
    task automatic frame(input logic m3, input int n);
        host.start(m3);
        for (int i = 0; i < n; i++) host.xfer(tx[i], rx[i]);
        host.stop();
    endtask
    task automatic op1(input logic [7:0] op);
        tx[0] = op;
        frame(1'b0, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cmp8({7'h0, so_oe}, 8'h00);
        chk_st(8'h00);
        tx = '{8'h01, 8'h8C, 8'h00, 8'h00, 8'h00};
        frame(1'b0, 2);
        chk_st(8'h00);
    endtask
    task automatic t_latch();
        op1(8'h06);
        chk_st(8'h02);
        tx[0] = 8'h05;
        frame(1'b1, 2);
        cmp8(rx[1], 8'h02);
        cmp8({7'h0, so_oe}, 8'h00);
        chk_st(8'h02);
        cmp8({7'h0, mode3}, 8'h01);
        op1(8'h04);
        chk_st(8'h00);
        cmp8({7'h0, mode3}, 8'h00);
    endtask
    task automatic t_one_cmd();
        tx = '{8'h04, 8'h06, 8'h00, 8'h00, 8'h00};
        frame(1'b0, 2);
        chk_st(8'h00);
        tx = '{8'hAA, 8'h06, 8'h00, 8'h00, 8'h00};
        frame(1'b0, 2);
        chk_st(8'h00);
    endtask
    task automatic t_status_wr();
        op1(8'h06);
        tx = '{8'h01, 8'hFF, 8'h00, 8'h00, 8'h00};
        frame(1'b0, 2);
        chk_st(8'h8C);
        host.protect(1'b0);
        op1(8'h06);
        tx[0] = 8'h01;
        tx[1] = 8'h00;
        frame(1'b0, 2);
        chk_st(8'h8E);
        host.protect(1'b1);
        frame(1'b0, 2);
        chk_st(8'h00);
    endtask
    task automatic t_memory();
        host.protect(1'b0);
        op1(8'h06);
        tx = '{8'h02, 8'hFF, 8'hFF, 8'h11, 8'h22};
        frame(1'b0, 5);
        tx = '{8'h03, 8'h07, 8'hFF, 8'h00, 8'h00};
        frame(1'b0, 5);
        cmp8(rx[3], 8'h11);
        cmp8(rx[4], 8'h22);
        chk_st(8'h00);
        tx = '{8'h02, 8'h00, 8'h00, 8'h55, 8'h00};
        frame(1'b0, 4);
        tx = '{8'h03, 8'hF8, 8'h00, 8'h00, 8'h00};
        frame(1'b0, 4);
        cmp8(rx[3], 8'h22);
        host.protect(1'b1);
    endtask
    task automatic t_hold();
        op1(8'h06);
        host.start(1'b0);
        host.xfer(8'h05, r0);
        host.pause(oe_seen);
        cmp8({7'h0, oe_seen}, 8'h00);
        host.xfer(8'h00, r1);
        host.stop();
        cmp8(r1, 8'h02);
    endtask
    task automatic t_clk_en();
        @(posedge sys_clk_i);
        #1 clk_en = 1'b0;
        op1(8'h04);
        repeat (6) @(posedge sys_clk_i);
        #1;
        cmp8(status, 8'h02);
        clk_en = 1'b1;
        chk_st(8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sys_clk_i);
        #1 nrst_i = 1'b1;
        t_reset();
        t_latch();
        t_one_cmd();
        t_status_wr();
        t_memory();
        t_hold();
        t_clk_en();
        tally_and_finish();
    end
    initial begin
        #300000;
        fails++;
        tally_and_finish();
    end
endmodule
